// ---- pkg/pfs_pkg.sv ----
// Package: register map, field positions and timing for the fault supervisor
package pfs_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned OT_HOLD_MS = 1000;
   localparam int unsigned HB_HALF_MS = 500;
   localparam int unsigned OT_HOLD_CYC = CLK_HZ / 1000 * OT_HOLD_MS;
   localparam int unsigned HB_HALF_CYC = CLK_HZ / 1000 * HB_HALF_MS;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned SPI_DIV = 8;
   localparam int unsigned SPI_BITS = 32;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FAULT = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0c;
   localparam logic [7:0] ADDR_TEMP = 8'h10;
   localparam logic [7:0] ADDR_THR = 8'h14;
   localparam logic [7:0] ADDR_AUXRD = 8'h18;
   localparam logic [7:0] ADDR_TCRD = 8'h1c;
   localparam logic [7:0] ADDR_PMSEL = 8'h20;
   localparam logic [7:0] ADDR_PMDAT = 8'h24;

   // Control fields
   localparam int unsigned CTRL_OUT_EN = 0;
   localparam int unsigned CTRL_CC_MODE = 1;
   localparam int unsigned CTRL_DIAG_OK = 2;
   localparam int unsigned CTRL_TC_GO = 3;

   // Fault/event bit positions, common to status and mask
   localparam int unsigned EV_OT = 0;
   localparam int unsigned EV_DCL = 1;
   localparam int unsigned EV_ILK = 2;
   localparam int unsigned EV_TC = 3;
   localparam int unsigned EV_W = 4;

   // Reset values
   localparam logic [15:0] OT_THR_RST = 16'd80;
   localparam int unsigned PM_N = 4;
   localparam logic [31:0] PM_VAL_RST = 32'h0000_0001;
   localparam int unsigned PM_AUX_SCALE = 0;
   // Entry word: [31:24] address, [23:8] name code, [7:0] privilege
   localparam logic [31:0] PM_ID0 = 32'h0000_5301;
   localparam logic [31:0] PM_ID1 = 32'h0100_5402;
   localparam logic [31:0] PM_ID2 = 32'h0200_5502;
   localparam logic [31:0] PM_ID3 = 32'h0300_5603;
   localparam logic [7:0] PM_RO_BIT = 8'h80;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_SHIFT = 2'b01,
      SPI_DONE = 2'b11
   } pfs_spi_type;
endpackage

// ---- rtl/pfs_top.sv ----
// Protection fault supervisor with indicators, parameter memory and SPI
`timescale 1ns/1ps
module pfs_top #(
   parameter int unsigned OT_HOLD = pfs_pkg::OT_HOLD_CYC,
   parameter int unsigned HB_HALF = pfs_pkg::HB_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] temp_i,
   input wire logic dcl_under_i,
   input wire logic dcl_over_i,
   input wire logic ilk_closed_n_i,
   input wire logic [15:0] aux_code_i,
   input wire logic aux_valid_i,
   input wire logic spi_miso_i,
   output logic spi_sclk_o,
   output logic spi_cs_n_o,
   output logic out_en_o,
   output logic led_cc_o,
   output logic led_hb_o,
   output logic led_out_o,
   output logic led_alarm_o,
   output logic irq_o
);
   typedef struct packed {
      logic [31:0] rdat;
      logic ack;
      logic [1:0] dcl_s1;
      logic [1:0] dcl_s2;
      logic ilk_s1;
      logic ilk_s2;
      logic miso_s1;
      logic miso_s2;
      logic out_req;
      logic cc_mode;
      logic diag_ok;
      logic [15:0] ot_thr;
      logic [pfs_pkg::CNT_W-1:0] ot_cnt;
      logic [pfs_pkg::CNT_W-1:0] hb_cnt;
      logic hb;
      logic [pfs_pkg::EV_W-1:0] fault;
      logic [pfs_pkg::EV_W-1:0] mask;
      logic out_en;
      logic [47:0] aux_rd;
      logic [pfs_pkg::SPI_BITS-1:0] tc_sh;
      logic [pfs_pkg::SPI_BITS-1:0] tc_rd;
      pfs_pkg::pfs_spi_type spi;
      logic [7:0] spi_bit;
      logic [3:0] spi_div;
      logic sclk;
      logic cs_n;
      logic [1:0] pm_sel;
      logic [pfs_pkg::PM_N-1:0][31:0] pm_val;
      logic led_cc;
      logic led_out;
      logic led_alarm;
      logic irq;
   } pfs_state_type;

   pfs_state_type r;
   pfs_state_type next_r;

   function automatic logic [31:0] pm_id(input logic [1:0] i);
      case (i)
         2'd0: pm_id = pfs_pkg::PM_ID0;
         2'd1: pm_id = pfs_pkg::PM_ID1;
         2'd2: pm_id = pfs_pkg::PM_ID2;
         default: pm_id = pfs_pkg::PM_ID3;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      merge = m;
   endfunction

   logic acc;
   logic wr;
   logic ot_hot;
   logic [pfs_pkg::EV_W-1:0] ev;
   logic [pfs_pkg::EV_W-1:0] clr;
   logic [pfs_pkg::EV_W-1:0] cause;
   logic spi_fin;

   always_comb begin
      next_r = r;
      acc = wb_cyc_i && wb_stb_i && !r.ack;
      wr = acc && wb_we_i;
      // ====================================================
      // Synchronisers: stage one only feeds stage two
      next_r.dcl_s1 = {dcl_over_i, dcl_under_i};
      next_r.dcl_s2 = r.dcl_s1;
      next_r.ilk_s1 = ilk_closed_n_i;
      next_r.ilk_s2 = r.ilk_s1;
      next_r.miso_s1 = spi_miso_i;
      next_r.miso_s2 = r.miso_s1;

      // ====================================================
      // Temperature persistence: must stay above for the whole hold time
      ot_hot = temp_i > r.ot_thr;
      if (!ot_hot) begin
         next_r.ot_cnt = '0;
      end else if (r.ot_cnt < pfs_pkg::CNT_W'(OT_HOLD)) begin
         next_r.ot_cnt = r.ot_cnt + 1'b1;
      end

      spi_fin = 1'b0;
      ev = '0;
      ev[pfs_pkg::EV_OT] = r.ot_cnt == pfs_pkg::CNT_W'(OT_HOLD - 1) && ot_hot;
      ev[pfs_pkg::EV_DCL] = |r.dcl_s2;
      ev[pfs_pkg::EV_ILK] = !r.ilk_s2;

      // Causes still present block the clear of their bit
      cause = '0;
      cause[pfs_pkg::EV_OT] = temp_i >= r.ot_thr;
      cause[pfs_pkg::EV_DCL] = |r.dcl_s2;
      cause[pfs_pkg::EV_ILK] = !r.ilk_s2;

      // ====================================================
      // Heartbeat, half-period toggle while diag_ok is set, held low otherwise
      if (!r.diag_ok) begin
         next_r.hb_cnt = '0;
         next_r.hb = 1'b0;
      end else if (r.hb_cnt == pfs_pkg::CNT_W'(HB_HALF - 1)) begin
         next_r.hb_cnt = '0;
         next_r.hb = !r.hb;
      end else begin
         next_r.hb_cnt = r.hb_cnt + 1'b1;
      end

      // ====================================================
      // Auxiliary scaling with the retained scale factor
      if (aux_valid_i) begin
         next_r.aux_rd = aux_code_i *
            r.pm_val[pfs_pkg::PM_AUX_SCALE];
      end

      // ====================================================
      // SPI master, mode 0, reads a 32-bit frame
      case (r.spi)
         pfs_pkg::SPI_IDLE: begin
            next_r.cs_n = 1'b1;
            next_r.sclk = 1'b0;
         end
         pfs_pkg::SPI_SHIFT: begin
            next_r.spi_div = r.spi_div + 1'b1;
            if (r.spi_div == 4'(pfs_pkg::SPI_DIV / 2 - 1)) begin
               next_r.sclk = 1'b1;
               next_r.tc_sh = {r.tc_sh[pfs_pkg::SPI_BITS-2:0], r.miso_s2};
            end else if (r.spi_div == 4'(pfs_pkg::SPI_DIV - 1)) begin
               next_r.sclk = 1'b0;
               next_r.spi_div = '0;
               next_r.spi_bit = r.spi_bit + 1'b1;
               if (r.spi_bit == 8'(pfs_pkg::SPI_BITS - 1)) begin
                  next_r.spi = pfs_pkg::SPI_DONE;
               end
            end
         end
         pfs_pkg::SPI_DONE: begin
            next_r.cs_n = 1'b1;
            next_r.tc_rd = r.tc_sh;
            spi_fin = 1'b1;
            next_r.spi = pfs_pkg::SPI_IDLE;
         end
         default: next_r.spi = pfs_pkg::SPI_IDLE;
      endcase
      ev[pfs_pkg::EV_TC] = spi_fin;

      // ====================================================
      // Bus slave, one wait state then ack
      next_r.ack = acc;
      clr = '0;
      if (wr) begin
         case (wb_adr_i)
            pfs_pkg::ADDR_CTRL: begin
               if (wb_sel_i[0]) begin
                  // An enable while a fault is latched is refused, so
                  // clearing the fault never restarts the output by itself
                  next_r.out_req = wb_dat_i[pfs_pkg::CTRL_OUT_EN] &&
                     (r.fault[pfs_pkg::EV_ILK:pfs_pkg::EV_OT] == '0);
                  next_r.cc_mode = wb_dat_i[pfs_pkg::CTRL_CC_MODE];
                  next_r.diag_ok = wb_dat_i[pfs_pkg::CTRL_DIAG_OK];
                  if (wb_dat_i[pfs_pkg::CTRL_TC_GO] &&
                      r.spi == pfs_pkg::SPI_IDLE) begin
                     next_r.spi = pfs_pkg::SPI_SHIFT;
                     next_r.cs_n = 1'b0;
                     next_r.spi_bit = '0;
                     next_r.spi_div = '0;
                  end
               end
            end
            pfs_pkg::ADDR_FAULT: begin
               if (wb_sel_i[0]) begin
                  clr = wb_dat_i[pfs_pkg::EV_W-1:0] & ~cause;
               end
            end
            pfs_pkg::ADDR_MASK: begin
               if (wb_sel_i[0]) begin
                  next_r.mask = wb_dat_i[pfs_pkg::EV_W-1:0];
               end
            end
            pfs_pkg::ADDR_THR: begin
               next_r.ot_thr = 16'(merge({16'h0000, r.ot_thr}, wb_dat_i,
                  wb_sel_i));
            end
            pfs_pkg::ADDR_PMSEL: begin
               if (wb_sel_i[0]) begin
                  next_r.pm_sel = wb_dat_i[1:0];
               end
            end
            pfs_pkg::ADDR_PMDAT: begin
               // Only the value word is storage; the id word has no write path
               if ((pm_id(r.pm_sel) & 32'(pfs_pkg::PM_RO_BIT)) == '0) begin
                  next_r.pm_val[r.pm_sel] = merge(r.pm_val[r.pm_sel],
                     wb_dat_i, wb_sel_i);
               end
            end
            default: begin
            end
         endcase
      end
      // A new fault drops the request; the host must enable again
      if (|ev[pfs_pkg::EV_ILK:pfs_pkg::EV_OT]) begin
         next_r.out_req = 1'b0;
      end
      // Set wins over clear
      next_r.fault = (r.fault & ~clr) | ev;

      // ====================================================
      // Read data, registered together with the ack
      next_r.rdat = '0;
      if (acc && !wb_we_i) begin
         case (wb_adr_i)
            pfs_pkg::ADDR_CTRL: next_r.rdat = {28'h0000000, 1'b0,
               r.diag_ok, r.cc_mode, r.out_req};
            pfs_pkg::ADDR_FAULT: next_r.rdat = 32'(r.fault);
            pfs_pkg::ADDR_MASK: next_r.rdat = 32'(r.mask);
            pfs_pkg::ADDR_STATE: next_r.rdat = {28'h0000000,
               r.hb, r.out_en, r.spi != pfs_pkg::SPI_IDLE, r.ilk_s2};
            pfs_pkg::ADDR_TEMP: next_r.rdat = {16'h0000, temp_i};
            pfs_pkg::ADDR_THR: next_r.rdat = {16'h0000, r.ot_thr};
            pfs_pkg::ADDR_AUXRD: next_r.rdat = r.aux_rd[31:0];
            pfs_pkg::ADDR_TCRD: next_r.rdat = r.tc_rd;
            pfs_pkg::ADDR_PMSEL: next_r.rdat = pm_id(r.pm_sel);
            pfs_pkg::ADDR_PMDAT: next_r.rdat = r.pm_val[r.pm_sel];
            default: next_r.rdat = '0;
         endcase
      end

      // ====================================================
      // Output only while requested and no OT, DCL or ILK fault latched
      next_r.out_en = next_r.out_req &&
         (next_r.fault[pfs_pkg::EV_ILK:pfs_pkg::EV_OT] == '0);
      next_r.led_out = next_r.out_en;
      next_r.led_cc = next_r.cc_mode;
      next_r.led_alarm = |next_r.fault[pfs_pkg::EV_ILK:pfs_pkg::EV_OT];
      next_r.irq = |(next_r.fault & next_r.mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.cs_n <= 1'b1;
         r.ilk_s1 <= 1'b1;
         r.ilk_s2 <= 1'b1;
         r.ot_thr <= pfs_pkg::OT_THR_RST;
         r.pm_val <= {pfs_pkg::PM_N{pfs_pkg::PM_VAL_RST}};
      end else begin
         r <= next_r;
      end
   end

   assign wb_dat_o = r.rdat;
   assign wb_ack_o = r.ack;
   assign spi_sclk_o = r.sclk;
   assign spi_cs_n_o = r.cs_n;
   assign out_en_o = r.out_en;
   assign led_cc_o = r.led_cc;
   assign led_hb_o = r.hb;
   assign led_out_o = r.led_out;
   assign led_alarm_o = r.led_alarm;
   assign irq_o = r.irq;

   // ==========================================================
   // Checks
   sequence s_hot_hold;
      (temp_i > r.ot_thr)[*8];
   endsequence

   a_alarm_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 led_alarm_o == |r.fault[2:0]) else $error("alarm mismatch");
   a_out_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
      (|r.fault[2:0]) |-> !out_en_o) else $error("output on with fault");
   a_cc_led: assert property (@(posedge clk_i) disable iff (rst_i)
      led_cc_o == r.cc_mode) else $error("cc led wrong");
   a_out_led: assert property (@(posedge clk_i) disable iff (rst_i)
      led_out_o == out_en_o) else $error("out led wrong");
   a_dcl_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      (|r.dcl_s2) |=> r.fault[pfs_pkg::EV_DCL]) else $error("dcl lost");
   a_ot_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (temp_i >= r.ot_thr && r.fault[pfs_pkg::EV_OT]) |=>
      r.fault[pfs_pkg::EV_OT]) else $error("ot cleared while hot");
   a_ot_nofast: assert property (@(posedge clk_i) disable iff (rst_i)
      ($rose(temp_i > r.ot_thr) && !r.fault[pfs_pkg::EV_OT]) |=>
      !r.fault[pfs_pkg::EV_OT]) else $error("ot too early");
   a_ilk_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.ilk_s2 |=> r.fault[pfs_pkg::EV_ILK]) else $error("ilk lost");
   a_hb_steady: assert property (@(posedge clk_i) disable iff (rst_i)
      (r.diag_ok && r.hb_cnt != pfs_pkg::CNT_W'(HB_HALF - 1)) |=>
      $stable(led_hb_o)) else $error("hb toggled early");
   a_hb_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      (r.diag_ok && r.hb_cnt == pfs_pkg::CNT_W'(HB_HALF - 1)) |=>
      $changed(led_hb_o)) else $error("hb missed toggle");
   a_ot_short: assert property (@(posedge clk_i) disable iff (rst_i)
      ($rose(temp_i > r.ot_thr) && !r.fault[pfs_pkg::EV_OT]) ##0 s_hot_hold
      |=> !r.fault[pfs_pkg::EV_OT]) else $error("ot before hold");
   a_event_alarm: assert property (@(posedge clk_i) disable iff (rst_i)
      (|ev[pfs_pkg::EV_ILK:pfs_pkg::EV_OT]) |=> (led_alarm_o && !out_en_o))
      else $error("event left output on");
   a_no_restart: assert property (@(posedge clk_i) disable iff (rst_i)
      (|r.fault[pfs_pkg::EV_ILK:pfs_pkg::EV_OT]) |=> !out_en_o)
      else $error("output restarted by clear");
endmodule

// ---- verif/pfs_tc_model.sv ----
// Thermocouple converter model answering on the supervisor's SPI link
`timescale 1ns/1ps
module pfs_tc_model (
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic [31:0] word_i,
   output logic spi_miso_o
);
   int idx = 0;
   logic last = 1'b0;
   initial spi_miso_o = 1'b1;
   // ==========================================
   // Shift out, most significant bit first
   always @(negedge spi_cs_n_i) begin
      idx = 31;
      last = word_i[31];
      spi_miso_o = last;
   end
   always @(negedge spi_sclk_i) begin
      if (!spi_cs_n_i && idx > 0) begin
         idx = idx - 1;
         last = word_i[idx];
         spi_miso_o = last;
      end
   end
   // Released line shows the inverse so a late sample cannot pass
   always @(posedge spi_cs_n_i) spi_miso_o = ~last;
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the protection fault supervisor
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
failures++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
   // ==========================================
   // Short counts keep the run brief
   localparam int unsigned OTH = 40;
   localparam int unsigned HBH = 25;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] tcw = 32'h0;
   logic [31:0] dato;
   logic [31:0] seed = 32'h0000_002f;
   logic [15:0] temp = 16'h0014;
   logic [15:0] aux = 16'h0000;
   logic ack, miso, sclk, cs_n, oen, lcc, lhb, lout, alarm, irq, hb;
   logic dcu = 1'b0;
   logic dco = 1'b0;
   logic ilk_n = 1'b1;
   logic auxv = 1'b0;
   int failures = 0;
   int check_count = 0;
   int cyc_n = 0;
   int exp_fault = 0;
   int n, k;
   int scale_q[$];
   pfs_top #(.OT_HOLD(OTH), .HB_HALF(HBH)) pfs_top_inst (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dato),
      .wb_ack_o(ack), .temp_i(temp), .dcl_under_i(dcu), .dcl_over_i(dco),
      .ilk_closed_n_i(ilk_n), .aux_code_i(aux), .aux_valid_i(auxv),
      .spi_miso_i(miso), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
      .out_en_o(oen), .led_cc_o(lcc), .led_hb_o(lhb), .led_out_o(lout),
      .led_alarm_o(alarm), .irq_o(irq));
   pfs_tc_model pfs_tc_model_inst (.spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
      .word_i(tcw), .spi_miso_o(miso));
   initial forever #2 clk_i = ~clk_i;
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] ctl(input logic oe, input logic cc,
                                       input logic go);
      logic [31:0] v;
      v = 32'h0;
      v[pfs_pkg::CTRL_OUT_EN] = oe;
      v[pfs_pkg::CTRL_CC_MODE] = cc;
      v[pfs_pkg::CTRL_DIAG_OK] = 1'b1;
      v[pfs_pkg::CTRL_TC_GO] = go;
      return v;
   endfunction
   // ==========================================
   // Classic single cycle; entered just after a rising edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   task automatic chk_fault();
      wb(1'b0, pfs_pkg::ADDR_FAULT, 32'h0);
      `CHK("fault", 4'(exp_fault), rdat[3:0])
      `CHK("alarm", exp_fault != 0, alarm)
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A hang counts as a mismatch
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 30000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      tick(4);
      rst_i <= 1'b0;
      tick(1);
      wb(1'b0, pfs_pkg::ADDR_THR, 32'h0);
      `CHK("thr", 16'd80, rdat[15:0])
      chk_fault();
      for (n = 0; n < 2; n++) begin
         wb(1'b1, pfs_pkg::ADDR_CTRL, ctl(1'b1, n[0], 1'b0));
         `CHK("led_cc", n[0], lcc)
         `CHK("led_out", 1'b1, lout)
      end
      $display("test modes done");
      hb = lhb;
      for (n = 0; n < 200 && lhb === hb; n++) @(posedge clk_i);
      hb = lhb;
      for (n = 0; n < 200 && lhb === hb; n++) @(posedge clk_i);
      `CHK("hb_half", HBH, n)
      $display("test heartbeat done");
      // A hot spell shorter than the hold time must not trip
      temp <= 16'd81;
      tick(OTH - 10);
      temp <= 16'd50;
      tick(3);
      chk_fault();
      temp <= 16'd81;
      tick(OTH + 5);
      exp_fault = 1 << pfs_pkg::EV_OT;
      chk_fault();
      `CHK("out_en", 1'b0, oen)
      temp <= 16'd80;
      wb(1'b1, pfs_pkg::ADDR_FAULT, 32'(exp_fault));
      chk_fault();
      wb(1'b1, pfs_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0));
      `CHK("out_en", 1'b0, oen)
      temp <= 16'd50;
      tick(2);
      wb(1'b1, pfs_pkg::ADDR_FAULT, 32'(exp_fault));
      exp_fault = 0;
      chk_fault();
      wb(1'b1, pfs_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0));
      `CHK("out_en", 1'b1, oen)
      $display("test overtemp done");
      for (n = 0; n < 3; n++) begin
         wb(1'b1, pfs_pkg::ADDR_MASK, (n == 1) ? 32'h0 : 32'hf);
         dcu <= (n == 0);
         dco <= (n == 1);
         ilk_n <= (n != 2);
         tick(3);
         k = (n == 2) ? pfs_pkg::EV_ILK : pfs_pkg::EV_DCL;
         exp_fault = 1 << k;
         chk_fault();
         `CHK("irq", n != 1, irq)
         wb(1'b1, pfs_pkg::ADDR_FAULT, 32'(exp_fault));
         chk_fault();
         wb(1'b1, pfs_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0));
         `CHK("out_en", 1'b0, oen)
         dcu <= 1'b0;
         dco <= 1'b0;
         ilk_n <= 1'b1;
         tick(3);
         wb(1'b1, pfs_pkg::ADDR_FAULT, 32'(exp_fault));
         exp_fault = 0;
         chk_fault();
         `CHK("irq", 1'b0, irq)
      end
      // Clearing the faults must not bring the output back unasked
      wb(1'b0, pfs_pkg::ADDR_STATE, 32'h0);
      `CHK("state", 3'h1, rdat[2:0])
      `CHK("out_en", 1'b0, oen)
      wb(1'b0, pfs_pkg::ADDR_TEMP, 32'h0);
      `CHK("temp", 16'h0032, rdat[15:0])
      $display("test events done");
      scale_q = '{1, 3, 3};
      for (n = 0; n < 3; n++) begin
         if (n == 1) begin
            wb(1'b1, pfs_pkg::ADDR_PMSEL, pfs_pkg::PM_AUX_SCALE);
            wb(1'b1, pfs_pkg::ADDR_PMDAT, 32'h3);
            wb(1'b0, pfs_pkg::ADDR_PMSEL, 32'h0);
            `CHK("pm_id", pfs_pkg::PM_ID0, rdat)
         end
         aux <= 16'(rnd());
         auxv <= 1'b1;
         tick(1);
         auxv <= 1'b0;
         tick(3);
         wb(1'b0, pfs_pkg::ADDR_AUXRD, 32'h0);
         k = scale_q.pop_front();
         `CHK("aux", 32'(aux) * 32'(k), rdat)
      end
      $display("test aux done");
      tcw <= rnd();
      wb(1'b1, pfs_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b1));
      wb(1'b1, pfs_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0));
      for (n = 0; n < 3000 && cs_n !== 1'b0; n++) @(posedge clk_i);
      for (n = 0; n < 3000 && cs_n !== 1'b1; n++) @(posedge clk_i);
      tick(4);
      wb(1'b0, pfs_pkg::ADDR_TCRD, 32'h0);
      `CHK("tc", tcw, rdat)
      wb(1'b0, pfs_pkg::ADDR_FAULT, 32'h0);
      `CHK("tc_event", 4'(1 << pfs_pkg::EV_TC), rdat[3:0])
      `CHK("alarm", 1'b0, alarm)
      `CHK("irq", 1'b1, irq)
      wb(1'b1, pfs_pkg::ADDR_FAULT, 32'(1 << pfs_pkg::EV_TC));
      `CHK("irq", 1'b0, irq)
      $display("test spi done");
      close_out();
   end
endmodule
